// ---- core/adc_amp_pkg.sv ----
// ----------------------------------------------------------------------------
// Shared constants for the converter control block
// ----------------------------------------------------------------------------
package adc_amp_pkg;

   // ----------------------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;      // pclk at 100 MHz
   localparam int unsigned CONV_TIME_NS = 20000;    // Typical conversion, 20 us
   localparam int unsigned RESULT_BITS = 10;        // Converter resolution
   // Whole conversion in clock cycles
   localparam int unsigned CONV_CYC = CONV_TIME_NS / CLK_PERIOD_NS;
   // Sample phase plus one phase per result bit share the conversion time
   localparam int unsigned STEP_CYC = CONV_CYC / (RESULT_BITS + 1);
   localparam logic [11:0] STEP_LAST = 12'(STEP_CYC - 1);
   localparam logic [3:0] MSB_POS = 4'(RESULT_BITS - 1);

   // ----------------------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------------------
   localparam int unsigned NUM_CH = 6;              // Shared analog pins 0..5
   localparam logic [2:0] AMP_CH = 3'h3;            // Channel with the amplifier

   // ----------------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------------------
   localparam logic [9:0] CTRL_IDX = 10'h010;       // converter_control_reg
   localparam logic [9:0] PINCFG_IDX = 10'h011;     // analog_pin_config_reg
   localparam logic [9:0] RES_HI_IDX = 10'h012;     // result_high_reg
   localparam logic [9:0] RES_LO_IDX = 10'h013;     // result_low_reg
   localparam logic [9:0] IRQ_STAT_IDX = 10'h014;   // Sticky event status
   localparam logic [9:0] IRQ_MASK_IDX = 10'h015;   // Interrupt mask
   localparam logic [9:0] PORT_OUT_IDX = 10'h016;   // Port output data / pin read
   localparam logic [9:0] PORT_DIR_IDX = 10'h017;   // Port drive enables
   localparam logic [9:0] AMP_CFG_IDX = 10'h0f7;    // channel3_amplifier_config

   // ----------------------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------------------
   localparam int unsigned CTRL_CH_LSB = 0;         // Channel select, 3 bits
   localparam int unsigned CTRL_START_BIT = 3;      // conversion_start_busy
   localparam int unsigned CTRL_EOC_BIT = 4;        // end_of_conversion_flag
   localparam int unsigned AMP_GAIN_LSB = 0;        // Gain code, 2 bits
   localparam int unsigned AMP_EN_BIT = 2;          // ch3_amp_enable
   localparam int unsigned EOC_EVT_BIT = 0;         // Status and mask position

   // ----------------------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------------------
   localparam logic [2:0] CH_RST = 3'h0;
   localparam logic [5:0] PIN6_RST = 6'h00;
   localparam logic [1:0] GAIN_RST = 2'h0;
   localparam logic AMP_EN_RST = 1'b0;
   localparam logic [9:0] RESULT_RST = 10'h000;
   localparam logic [31:0] WORD_RST = 32'h0000_0000;

   // ----------------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------------
   typedef enum logic [1:0]
   {
      GAIN_X5 = 2'h0,
      GAIN_X10 = 2'h1,
      GAIN_X15 = 2'h2,
      GAIN_X20 = 2'h3
   } gain_t;

   typedef enum logic [1:0]
   {
      SAR_IDLE,
      SAR_SAMPLE,
      SAR_BITS
   } sar_state_t;

endpackage : adc_amp_pkg

// ---- core/adc_channel_amp_control.sv ----
`timescale 1ns/10ps
module adc_channel_amp_control
   import adc_amp_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt
   output logic irq,
   // Shared analog pins, general-purpose side
   input wire logic [5:0] ain_in,
   output logic [5:0] ain_out,
   output logic [5:0] ain_oe,
   // Analog front end
   output logic [5:0] converter_input_sel,
   output logic amp_path_sel,
   output logic ch3_amp_enable,
   output logic ch3_gain_sel_hi,
   output logic ch3_gain_sel_lo,
   output logic sample_hold,
   output logic [9:0] dac_trial,
   input wire logic cmp_hi_async
);

   // ----------------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------------

   // One-hot pin decode of a channel code; codes 6 and 7 select nothing
   function automatic logic [5:0] ch_onehot(input logic [2:0] code);
      logic [5:0] hot;
      hot = 6'h00;
      if (code < 3'h6)
      begin
         hot = 6'h01 << code;
      end
      return hot;
   endfunction : ch_onehot

   // Register index from an APB byte address
   function automatic logic [9:0] reg_idx(input logic [11:0] addr);
      return addr[11:2];
   endfunction : reg_idx

   // ----------------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------------
   typedef struct packed
   {
      logic [2:0] chan_sel;      // Channel select field
      logic [5:0] pin_cfg;       // Pins reserved for analog use
      logic [5:0] port_out;      // Port output data
      logic [5:0] port_dir;      // Port drive enables
      logic amp_en;              // Amplifier on
      logic [1:0] amp_gain;      // Gain code
      logic eoc;                 // Sticky end-of-conversion event
      logic eoc_mask;            // converter_irq_enable
      logic [5:0] pin_meta;      // Pin synchroniser, first stage
      logic [5:0] pin_sync;      // Pin synchroniser, second stage
      logic cmp_meta;            // Comparator synchroniser, first stage
      logic cmp_sync;            // Comparator synchroniser, second stage
      logic [31:0] rdata;        // Read data, captured in the setup phase
   } ctl_t;

   ctl_t cur_ff;
   ctl_t nxt_cur;

   logic conv_busy;              // Conversion running
   logic conv_done;              // One-cycle pulse, result ready
   logic [9:0] conv_result;      // Last result
   logic conv_start;             // One-cycle launch pulse
   logic wr_en;                  // APB write takes effect this edge
   logic rd_setup;               // APB read setup phase
   logic hit;                    // Address is mapped
   logic [9:0] idx;              // Register index
   logic [5:0] route;            // Pin routed to the converter

   // ----------------------------------------------------------------------------
   // Converter sequencer
   // ----------------------------------------------------------------------------
   adc_sar_seq u_seq
   (
      .pclk(pclk),
      .presetn(presetn),
      .start(conv_start),
      .cmp_hi(cur_ff.cmp_sync),
      .busy(conv_busy),
      .done(conv_done),
      .sample_hold(sample_hold),
      .trial(dac_trial),
      .result(conv_result)
   );

   // ----------------------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------------------

   // Slave never stalls; reads come from the setup-phase capture
   assign idx = reg_idx(paddr);
   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign pready = 1'b1;

   // Mapped address check
   always_comb
   begin
      if (idx == CTRL_IDX || idx == PINCFG_IDX || idx == RES_HI_IDX)
      begin
         hit = 1'b1;
      end
      else if (idx == RES_LO_IDX || idx == IRQ_STAT_IDX || idx == IRQ_MASK_IDX)
      begin
         hit = 1'b1;
      end
      else if (idx == PORT_OUT_IDX || idx == PORT_DIR_IDX || idx == AMP_CFG_IDX)
      begin
         hit = 1'b1;
      end
      else
      begin
         hit = 1'b0;
      end
   end

   // Unmapped addresses answer with an error in the access phase
   assign pslverr = psel && penable && !hit;

   // Launch only when idle: a write during a conversion has no effect
   assign conv_start = wr_en && (idx == CTRL_IDX) && pwdata[CTRL_START_BIT]
                       && !conv_busy;

   // ----------------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------------
   always_comb
   begin
      logic [5:0] locked;
      locked = ch_onehot(cur_ff.chan_sel) | cur_ff.pin_cfg;
      nxt_cur = cur_ff;

      // Two-flop synchronisers for pins and comparator
      nxt_cur.pin_meta = ain_in;
      nxt_cur.pin_sync = cur_ff.pin_meta;
      nxt_cur.cmp_meta = cmp_hi_async;
      nxt_cur.cmp_sync = cur_ff.cmp_meta;

      // Completion event; a set in the clearing cycle wins
      nxt_cur.eoc = cur_ff.eoc | conv_done;

      // Register writes
      if (wr_en)
      begin
         if (idx == CTRL_IDX)
         begin
            // Channel frozen while converting so the mux never moves mid-sample
            if (!conv_busy)
            begin
               nxt_cur.chan_sel = pwdata[CTRL_CH_LSB +: 3];
            end
         end
         else if (idx == PINCFG_IDX)
         begin
            nxt_cur.pin_cfg = pwdata[5:0];
         end
         else if (idx == IRQ_STAT_IDX)
         begin
            // Write one to clear, unless completion lands this same cycle
            nxt_cur.eoc = (cur_ff.eoc & ~pwdata[EOC_EVT_BIT]) | conv_done;
         end
         else if (idx == IRQ_MASK_IDX)
         begin
            nxt_cur.eoc_mask = pwdata[EOC_EVT_BIT];
         end
         else if (idx == PORT_OUT_IDX)
         begin
            // Bits of analog pins keep their value
            nxt_cur.port_out = (cur_ff.port_out & locked) | (pwdata[5:0] & ~locked);
         end
         else if (idx == PORT_DIR_IDX)
         begin
            nxt_cur.port_dir = (cur_ff.port_dir & locked) | (pwdata[5:0] & ~locked);
         end
         else if (idx == AMP_CFG_IDX)
         begin
            // Only the low three bits exist; the rest are dropped
            nxt_cur.amp_en = pwdata[AMP_EN_BIT];
            nxt_cur.amp_gain = pwdata[AMP_GAIN_LSB +: 2];
         end
      end

      // Read capture in the setup phase; unmapped reads return zero
      if (rd_setup)
      begin
         nxt_cur.rdata = WORD_RST;
         if (idx == CTRL_IDX)
         begin
            nxt_cur.rdata[CTRL_CH_LSB +: 3] = cur_ff.chan_sel;
            nxt_cur.rdata[CTRL_START_BIT] = conv_busy;
            nxt_cur.rdata[CTRL_EOC_BIT] = cur_ff.eoc;
         end
         else if (idx == PINCFG_IDX)
         begin
            nxt_cur.rdata[5:0] = cur_ff.pin_cfg;
         end
         else if (idx == RES_HI_IDX)
         begin
            nxt_cur.rdata[7:0] = conv_result[9:2];
         end
         else if (idx == RES_LO_IDX)
         begin
            nxt_cur.rdata[1:0] = conv_result[1:0];
         end
         else if (idx == IRQ_STAT_IDX)
         begin
            nxt_cur.rdata[EOC_EVT_BIT] = cur_ff.eoc;
         end
         else if (idx == IRQ_MASK_IDX)
         begin
            nxt_cur.rdata[EOC_EVT_BIT] = cur_ff.eoc_mask;
         end
         else if (idx == PORT_OUT_IDX)
         begin
            nxt_cur.rdata[5:0] = cur_ff.pin_sync; // Pin levels, synchronised
         end
         else if (idx == PORT_DIR_IDX)
         begin
            nxt_cur.rdata[5:0] = cur_ff.port_dir;
         end
         else if (idx == AMP_CFG_IDX)
         begin
            nxt_cur.rdata[AMP_EN_BIT] = cur_ff.amp_en;
            nxt_cur.rdata[AMP_GAIN_LSB +: 2] = cur_ff.amp_gain;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // Amplifier starts in standby at the lowest gain
         cur_ff <= '{chan_sel: CH_RST, pin_cfg: PIN6_RST, port_out: PIN6_RST,
                     port_dir: PIN6_RST, amp_en: AMP_EN_RST, amp_gain: GAIN_RST,
                     eoc: 1'b0, eoc_mask: 1'b0, pin_meta: PIN6_RST,
                     pin_sync: PIN6_RST, cmp_meta: 1'b0, cmp_sync: 1'b0,
                     rdata: WORD_RST};
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

   // ----------------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------------

   // Routed pin follows the select field
   assign route = ch_onehot(cur_ff.chan_sel);
   assign converter_input_sel = route;

   // Other pins keep port function; analog pins never drive
   assign ain_out = cur_ff.port_out;
   assign ain_oe = cur_ff.port_dir & ~cur_ff.pin_cfg & ~route;

   // Channel 3 through the rectifier and amplifier when enabled
   assign amp_path_sel = route[AMP_CH] & cur_ff.amp_en;

   // Amplifier controls straight from the register, one cycle after write
   assign ch3_amp_enable = cur_ff.amp_en;
   assign ch3_gain_sel_hi = cur_ff.amp_gain[1];
   assign ch3_gain_sel_lo = cur_ff.amp_gain[0];

   // Settling waits after gain or channel changes are software's job;
   // no hardware interlock delays a launch

   // Level interrupt while the unmasked event is pending
   assign irq = cur_ff.eoc & cur_ff.eoc_mask;
   assign prdata = cur_ff.rdata;

endmodule : adc_channel_amp_control

// ---- core/adc_sar_seq.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Successive approximation sequencer for the 10-bit converter
// ----------------------------------------------------------------------------
module adc_sar_seq
   import adc_amp_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic start,
   input wire logic cmp_hi,
   // Status and data
   output logic busy,
   output logic done,
   output logic sample_hold,
   output logic [9:0] trial,
   output logic [9:0] result
);

   // Whole sequencer state
   typedef struct packed
   {
      sar_state_t state;
      logic [11:0] cnt;
      logic [3:0] bitpos;
      logic [9:0] sar;
      logic [9:0] result;
      logic done;
   } seq_t;

   seq_t cur_ff;
   seq_t nxt_cur;

   // ----------------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------------
   always_comb
   begin
      logic [9:0] kept;
      kept = '0;
      nxt_cur = cur_ff;
      nxt_cur.done = 1'b0;
      case (cur_ff.state)
         SAR_IDLE:
         begin
            // Sampling starts at once, no setup clocks
            if (start)
            begin
               nxt_cur.state = SAR_SAMPLE;
               nxt_cur.cnt = 12'h000;
            end
         end
         SAR_SAMPLE:
         begin
            nxt_cur.cnt = cur_ff.cnt + 12'h001;
            if (cur_ff.cnt == STEP_LAST)
            begin
               nxt_cur.state = SAR_BITS;
               nxt_cur.cnt = 12'h000;
               nxt_cur.bitpos = MSB_POS;
               nxt_cur.sar = 10'h200;
            end
         end
         SAR_BITS:
         begin
            nxt_cur.cnt = cur_ff.cnt + 12'h001;
            if (cur_ff.cnt == STEP_LAST)
            begin
               // Drop the trial bit when the input is below the trial level
               kept = cmp_hi ? cur_ff.sar : (cur_ff.sar & ~(10'h001 << cur_ff.bitpos));
               nxt_cur.cnt = 12'h000;
               if (cur_ff.bitpos == 4'h0)
               begin
                  // Ten-bit result complete after about 20 us
                  nxt_cur.result = kept;
                  nxt_cur.sar = kept;
                  nxt_cur.done = 1'b1;
                  nxt_cur.state = SAR_IDLE;
               end
               else
               begin
                  nxt_cur.bitpos = cur_ff.bitpos - 4'h1;
                  nxt_cur.sar = kept | (10'h001 << (cur_ff.bitpos - 4'h1));
               end
            end
         end
         default:
         begin
            nxt_cur.state = SAR_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cur_ff <= '{state: SAR_IDLE, cnt: 12'h000, bitpos: 4'h0, sar: RESULT_RST,
                     result: RESULT_RST, done: 1'b0};
      end
      else
      begin
         cur_ff <= nxt_cur;
      end
   end

   // Outputs
   assign busy = (cur_ff.state != SAR_IDLE);
   assign done = cur_ff.done;
   assign sample_hold = (cur_ff.state == SAR_SAMPLE);
   assign trial = cur_ff.sar;
   assign result = cur_ff.result;

endmodule : adc_sar_seq

// ---- verification/adc_amp_chk.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Port checker for the converter control block
// ----------------------------------------------------------------------------
module adc_amp_chk
   import adc_amp_pkg::*;
(
   // Clock, reset and bus
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Outputs watched
   input wire logic irq,
   input wire logic [5:0] ain_oe,
   input wire logic [5:0] converter_input_sel,
   input wire logic amp_path_sel,
   input wire logic ch3_amp_enable,
   input wire logic ch3_gain_sel_hi,
   input wire logic ch3_gain_sel_lo,
   input wire logic sample_hold,
   input wire logic [9:0] dac_trial
);
   localparam logic [11:0] A_AMP = {AMP_CFG_IDX, 2'b00};
   localparam logic [11:0] A_CTRL = {CTRL_IDX, 2'b00};
   localparam logic [11:0] A_MASK = {IRQ_MASK_IDX, 2'b00};
   wire logic wr = psel && penable && pwrite; // Write takes effect
   wire logic [2:0] amp = {ch3_amp_enable, ch3_gain_sel_hi, ch3_gain_sel_lo};
   logic [11:0] cnt_ff; // Cycles since sampling began, saturating
   // Counter restarts on each launch so the completion time can be judged
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) cnt_ff <= 12'h000;
      else if ($rose(sample_hold)) cnt_ff <= 12'h001;
      else if (cnt_ff != 12'hfff) cnt_ff <= cnt_ff + 12'h001;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_AMP_WR: assert property (wr && paddr == A_AMP |=> amp == $past(pwdata[2:0]))
      else $error("amplifier controls did not follow write");
   AST_AMP_HOLD: assert property (!(wr && paddr == A_AMP) |=> $stable(amp))
      else $error("amplifier controls moved without write");
   AST_PATH: assert property (amp_path_sel == (converter_input_sel[3] && ch3_amp_enable))
      else $error("amplified path select wrong");
   AST_SEL: assert property ($onehot0(converter_input_sel))
      else $error("more than one pin routed");
   AST_OE: assert property ((ain_oe & converter_input_sel) == 6'h00)
      else $error("routed pin driven");
   AST_LAUNCH: assert property ($rose(sample_hold) |-> $past(wr && paddr == A_CTRL && pwdata[3]))
      else $error("sampling without start");
   AST_SAMPLE: assert property ($rose(sample_hold) |-> ##180 sample_hold ##1 !sample_hold)
      else $error("sample phase length wrong");
   AST_MSB: assert property ($fell(sample_hold) |-> dac_trial == 10'h200)
      else $error("first trial not msb");
   AST_IRQ_RISE: assert property ($rose(irq) |-> cnt_ff inside {[12'h7c1:12'h7cb]} ||
      $past(wr && paddr == A_MASK))
      else $error("interrupt rose at wrong time");
   AST_MASK_OFF: assert property (wr && paddr == A_MASK && !pwdata[0] |=> !irq)
      else $error("masked interrupt still high");
   AST_FREEZE: assert property (sample_hold && wr && paddr == A_CTRL |=>
      $stable(converter_input_sel))
      else $error("channel changed while busy");
endmodule : adc_amp_chk
bind adc_channel_amp_control adc_amp_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .irq(irq),
   .ain_oe(ain_oe), .converter_input_sel(converter_input_sel), .amp_path_sel(amp_path_sel),
   .ch3_amp_enable(ch3_amp_enable), .ch3_gain_sel_hi(ch3_gain_sel_hi),
   .ch3_gain_sel_lo(ch3_gain_sel_lo), .sample_hold(sample_hold), .dac_trial(dac_trial));

// ---- verification/adc_front_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Analog pins, comparator and channel 3 amplifier seen by the block
// ----------------------------------------------------------------------------
module adc_front_model
(
   // Routing and amplifier controls
   input wire logic [5:0] sel,
   input wire logic amp_on,
   input wire logic [1:0] gain,
   input wire logic [9:0] trial,
   // General-purpose pin side
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] pin_out,
   // Answers
   output logic cmp,
   output logic [5:0] pin_in
);
   // Level of each pin as a converter code; ch3 is the averaged rectified level
   localparam logic [9:0] LVL [6] = '{10'h3ff, 10'h155, 10'h1a5, 10'h030, 10'h2aa, 10'h0f0};
   localparam logic [5:0] EXT = 6'h02; // Outside source on undriven pins
   int lvl;
   // Averaging settles at once, so the bench may shorten its settling waits
   always_comb
   begin
      lvl = 0;
      for (int i = 0; i < 6; i++)
         if (sel[i]) lvl = LVL[i];
      if (sel[3] && amp_on) lvl = lvl * (5 * (gain + 1));
      if (lvl > 1023) lvl = 1023; // Clips at full scale
      cmp = (lvl >= trial);
   end
   // Driven pins read back their own level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & EXT);
endmodule : adc_front_model

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------------------
// Self-checking bench for the converter control block
// ----------------------------------------------------------------------------
module tb_top;
   import adc_amp_pkg::*;
   localparam int SETTLE_CYC = 2000; // 20 us; model averaging settles at once
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, irq, path, amp_en, g_hi, g_lo, hold, cmp;
   wire logic [5:0] pin_in, pin_out, pin_oe, sel;
   wire logic [9:0] trial;
   int n_mismatch = 0, num_checks = 0, cyc = 0, t0;
   adc_channel_amp_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .ain_in(pin_in), .ain_out(pin_out),
      .ain_oe(pin_oe), .converter_input_sel(sel), .amp_path_sel(path),
      .ch3_amp_enable(amp_en), .ch3_gain_sel_hi(g_hi), .ch3_gain_sel_lo(g_lo),
      .sample_hold(hold), .dac_trial(trial), .cmp_hi_async(cmp));
   adc_front_model u_front (.sel(sel), .amp_on(amp_en), .gain({g_hi, g_lo}), .trial(trial),
      .pin_oe(pin_oe), .pin_out(pin_out), .cmp(cmp), .pin_in(pin_in));
   always #5 pclk = ~pclk;
   // Cuts a hang short
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // One whole APB transfer; read data and error taken at the pready edge
   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic t_amp();
      apb(0, AMP_CFG_IDX, 0);
      chk(rd, 32'h0);
      chk({amp_en, g_hi, g_lo}, 3'h0);
      chk(sel, 6'h01);
      apb(1, AMP_CFG_IDX, 32'hff);
      apb(0, AMP_CFG_IDX, 0);
      chk(rd, 32'h7);
      for (int g = 0; g < 4; g++)
      begin
         apb(1, AMP_CFG_IDX, 32'(4 + g));
         @(negedge pclk);
         chk({amp_en, g_hi, g_lo}, 32'(4 + g));
      end
      apb(1, AMP_CFG_IDX, 32'h3);
      @(negedge pclk);
      chk(amp_en, 1'b0);
   endtask : t_amp
   task automatic t_route();
      for (int c = 0; c < 8; c++)
      begin
         apb(1, CTRL_IDX, 32'(c));
         @(negedge pclk);
         chk(sel, (c < 6) ? 32'(1 << c) : 32'h0);
      end
   endtask : t_route
   task automatic t_pins();
      apb(1, CTRL_IDX, 1);
      apb(1, PORT_DIR_IDX, 32'h3f);
      apb(1, PORT_OUT_IDX, 32'h2a);
      @(negedge pclk);
      chk(pin_oe, 6'h3d);
      chk(pin_out, 6'h28);
      // Pin levels pass a two-flop synchroniser before the read capture sees them
      repeat (2) @(posedge pclk);
      apb(0, PORT_OUT_IDX, 0);
      chk(rd, 32'h2a);
      apb(0, 10'h3ff, 0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
   endtask : t_pins
   task automatic t_conv();
      apb(1, IRQ_MASK_IDX, 1);
      apb(1, CTRL_IDX, 32'h0a);
      t0 = cyc;
      @(negedge pclk);
      chk(hold, 1'b1);
      apb(1, CTRL_IDX, 32'h0d);
      @(negedge pclk);
      chk(sel, 6'h04);
      apb(0, CTRL_IDX, 0);
      chk(rd[3], 1'b1);
      while (irq !== 1'b1 && cyc - t0 < 2100) @(posedge pclk);
      chk(cyc - t0 >= 1989 && cyc - t0 <= 1994, 1'b1);
      apb(0, RES_HI_IDX, 0);
      chk(rd, 32'h69);
      apb(0, RES_LO_IDX, 0);
      chk(rd, 32'h1);
      apb(0, CTRL_IDX, 0);
      chk(rd, 32'h12);
      apb(1, IRQ_STAT_IDX, 1);
      @(negedge pclk);
      chk(irq, 1'b0);
   endtask : t_conv
   task automatic t_amp_conv();
      apb(1, AMP_CFG_IDX, 32'h5);
      apb(1, CTRL_IDX, 3);
      apb(1, IRQ_MASK_IDX, 0);
      repeat (SETTLE_CYC) @(posedge pclk);
      chk(path, 1'b1);
      apb(1, CTRL_IDX, 32'h0b);
      repeat (2000) @(posedge pclk);
      chk(irq, 1'b0);
      apb(0, IRQ_STAT_IDX, 0);
      chk(rd, 32'h1);
      apb(0, RES_HI_IDX, 0);
      chk(rd, 32'h78);
      apb(1, IRQ_MASK_IDX, 1);
      @(negedge pclk);
      chk(irq, 1'b1);
      apb(1, IRQ_STAT_IDX, 1);
   endtask : t_amp_conv
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_amp();
      t_route();
      t_pins();
      t_conv();
      t_amp_conv();
      finish_test();
   end
endmodule : tb_top
